// ---- include/adc_ctl_map.svh ----
// Register map, field positions, reset values and timing counts of the converter control block
`ifndef ADC_CTL_MAP_SVH
`define ADC_CTL_MAP_SVH
// ==========================================================
// Register addresses
`define ADDR_CONTROL    32'hFFFF0500
`define ADDR_POS_SEL    32'hFFFF0504
`define ADDR_NEG_SEL    32'hFFFF0508
`define ADDR_STATUS     32'hFFFF050C
`define ADDR_RESULT     32'hFFFF0510
`define ADDR_SOFT_RST   32'hFFFF0514
`define ADDR_PORT_CFG   32'hFFFF0530
// ==========================================================
// Control fields
`define CTL_RESET       32'h00000A00
`define CTL_WR_MASK     32'h0000FFBF
`define CTL_POS_BYP     15
`define CTL_NEG_BYP     14
`define CTL_DIV_HI      13
`define CTL_DIV_LO      11
`define CTL_ACQ_HI      10
`define CTL_ACQ_LO      8
`define CTL_ENABLE      7
`define CTL_POWER       5
`define CTL_MODE_HI     4
`define CTL_MODE_LO     3
`define CTL_TRIG_HI     2
`define CTL_TRIG_LO     0
// Status and result layout
`define STA_READY       0
`define RES_LO          16
`define RESULT_W        12
// Input modes and trigger codes
`define MODE_DIFF       2'h1
`define TRIG_PIN        3'h0
`define TRIG_TIMER1     3'h1
`define TRIG_TIMER0     3'h2
`define TRIG_SW_SINGLE  3'h3
`define TRIG_SW_CONT    3'h4
`define TRIG_PLA        3'h5
// ==========================================================
// Timing
`define CONV_EXTRA      19
`define CLK_PERIOD_NS   50
`define PWR_SETTLE_NS   5000
`define PWR_CYC         ((`PWR_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- include/adc_ctl_pkg.sv ----
// Types shared by the converter control block
package adc_ctl_pkg;
   // ==========================================================
   // Sequencer phases
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_ACQ,
      PH_CONV
   } phase_t;

   // ==========================================================
   // Whole state of the block
   typedef struct packed {
      phase_t      phase;     // Sequencer phase
      logic [31:0] control;   // Control register
      logic [4:0]  pos_sel;   // Positive channel select
      logic [4:0]  neg_sel;   // Negative channel select
      logic        ready;     // Conversion ready flag
      logic [11:0] result;    // Last result
      logic        res_sgn;   // Result taken in differential mode
      logic        port_cfg;  // Pin two carries busy
      logic [4:0]  div_cnt;   // Core clocks within a converter clock
      logic [6:0]  step;      // Converter clocks within a phase
      logic [6:0]  pwr_cnt;   // Power-up settle counter
      logic        pin_prev;  // Previous external pin level
      logic        busy;      // Busy output
      logic        hold;      // Sample and hold output
      logic        pin_two;   // Port pin two output
      logic        irq;       // Completion pulse
      logic        tick;      // Converter clock pulse
      logic [31:0] rdata;     // Read data
   } state_t;
endpackage

// ---- hw/adc_control_status_logic.sv ----
// Converter control, status and sequencing logic
//
// Summary of operation
// (R01) Status holds only ready flag, bit 0
// (R02) Completion sets ready and raises interrupt
// (R03) Reading result clears ready flag
// (R04) Busy high throughout each conversion
// (R05) Busy on pin two only when configured
// (R06) Result holds latest 12-bit outcome
// (R07) Soft reset write restores all defaults except port configuration
// (R08) Control resets to 0x00000A00
// (R09) Control bits 31:16 have no effect
// (R10) Bit 15 bypasses positive buffer
// (R11) Bit 14 bypasses negative buffer
// (R12) Bits 13:11 divide core clock
// (R13) Conversion lasts acquisition plus 19 clocks
// (R14) Bits 10:8 set acquisition length
// (R15) Bit 7 enables conversions
// (R16) Bit 5 powers up; settle 5 us
// (R17) Bits 4:3 select input mode
// (R18) Bits 2:0 trigger; single reverts to 000
// (R19) Sequencer counts acquisition then conversion clocks
// (R20) Reserved control bits read zero
`include "adc_ctl_map.svh"

module adc_control_status_logic
   import adc_ctl_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [31:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic [31:0]      rdata,
   input  wire logic [11:0] analog_result,
   input  wire logic        external_convert_pin,
   input  wire logic        timer0_trigger,
   input  wire logic        timer1_trigger,
   input  wire logic        programmable_logic_source,
   output logic             positive_buffer_bypass,
   output logic             negative_buffer_bypass,
   output logic             converter_power_up,
   output logic [1:0]       input_mode,
   output logic [4:0]       positive_input_select,
   output logic [4:0]       negative_input_select,
   output logic             sample_hold,
   output logic             converter_clk_tick,
   output logic             conversion_busy_output,
   output logic             port_zero_pin_two,
   output logic             conversion_irq
);

   // ==========================================================
   // State and decoded fields
   state_t      state_ff;   // Registered state
   state_t      nxt_state;  // Next state
   logic [2:0]  div_code;   // Clock divider code
   logic [2:0]  acq_code;   // Acquisition code
   logic [2:0]  trig;       // Trigger code
   logic [4:0]  div_last;   // Last core clock of a converter clock
   logic [6:0]  acq_last;   // Last acquisition clock
   logic        settled;    // Power-up settle time elapsed
   logic        trig_hit;   // Selected trigger fired
   logic        start;      // Begin a conversion
   logic        tick;       // Converter clock edge this cycle
   logic        done;       // Conversion finishes this cycle
   logic        soft_rst;   // Soft reset write

   assign div_code = state_ff.control[`CTL_DIV_HI:`CTL_DIV_LO];
   assign acq_code = state_ff.control[`CTL_ACQ_HI:`CTL_ACQ_LO];
   assign trig     = state_ff.control[`CTL_TRIG_HI:`CTL_TRIG_LO];
   assign settled  = state_ff.pwr_cnt == 7'(`PWR_CYC);
   assign soft_rst = wr_en && addr == `ADDR_SOFT_RST && wdata[0];

   // ==========================================================
   // Divider and acquisition decode
   // Reserved divider codes fall back to the slowest rate so the core is never overclocked
   always_comb begin
      case (div_code) // see (R12)
         3'h0:    div_last = 5'h00;
         3'h1:    div_last = 5'h01;
         3'h2:    div_last = 5'h03;
         3'h3:    div_last = 5'h07;
         3'h4:    div_last = 5'h0F;
         default: div_last = 5'h1F;
      endcase
      case (acq_code) // see (R14)
         3'h0:    acq_last = 7'h01;
         3'h1:    acq_last = 7'h03;
         3'h2:    acq_last = 7'h07;
         3'h3:    acq_last = 7'h0F;
         3'h4:    acq_last = 7'h1F;
         default: acq_last = 7'h3F;
      endcase
   end

   // ==========================================================
   // Trigger selection
   always_comb begin
      case (trig) // see (R18)
         `TRIG_PIN:       trig_hit = external_convert_pin && !state_ff.pin_prev;
         `TRIG_TIMER1:    trig_hit = timer1_trigger;
         `TRIG_TIMER0:    trig_hit = timer0_trigger;
         `TRIG_SW_SINGLE: trig_hit = 1'b1;
         `TRIG_SW_CONT:   trig_hit = 1'b1;
         `TRIG_PLA:       trig_hit = programmable_logic_source;
         default:         trig_hit = 1'b0;
      endcase
   end

   // Triggers while busy are dropped; the core cannot take a second sample
   assign start = state_ff.phase == PH_IDLE && state_ff.control[`CTL_ENABLE] // see (R15)
                  && state_ff.control[`CTL_POWER] && settled && trig_hit && !soft_rst; // see (R16)
   assign tick  = state_ff.phase != PH_IDLE && state_ff.div_cnt == div_last; // see (R12)
   assign done  = tick && state_ff.phase == PH_CONV && state_ff.step == 7'(`CONV_EXTRA - 1); // see (R13)

   // ==========================================================
   // Next-state logic
   always_comb begin
      nxt_state          = state_ff;
      nxt_state.irq      = 1'b0;
      nxt_state.tick     = tick;
      nxt_state.rdata    = 32'h00000000;
      nxt_state.pin_prev = external_convert_pin;
      // Power-up settle counter restarts whenever power is removed
      if (!state_ff.control[`CTL_POWER]) begin
         nxt_state.pwr_cnt = 7'h00;
      end else if (!settled) begin
         nxt_state.pwr_cnt = state_ff.pwr_cnt + 7'h01; // see (R16)
      end
      // Register reads, answered in the next cycle
      if (rd_en) begin
         case (addr)
            `ADDR_CONTROL:  nxt_state.rdata = state_ff.control & `CTL_WR_MASK; // see (R20)
            `ADDR_POS_SEL:  nxt_state.rdata = {27'h0000000, state_ff.pos_sel};
            `ADDR_NEG_SEL:  nxt_state.rdata = {27'h0000000, state_ff.neg_sel};
            `ADDR_STATUS:   nxt_state.rdata = {31'h00000000, state_ff.ready}; // see (R01)
            `ADDR_RESULT: begin
               nxt_state.rdata = {{4{state_ff.res_sgn & state_ff.result[11]}}, state_ff.result,
                                  16'h0000}; // see (R06)
               nxt_state.ready = 1'b0; // see (R03)
            end
            `ADDR_PORT_CFG: nxt_state.rdata = {31'h00000000, state_ff.port_cfg};
            default:        nxt_state.rdata = 32'h00000000;
         endcase
      end
      // Register writes; reserved control bits are dropped
      if (wr_en) begin
         case (addr)
            `ADDR_CONTROL:  nxt_state.control = wdata & `CTL_WR_MASK; // see (R09)
            `ADDR_POS_SEL:  nxt_state.pos_sel = wdata[4:0];
            `ADDR_NEG_SEL:  nxt_state.neg_sel = wdata[4:0];
            `ADDR_PORT_CFG: nxt_state.port_cfg = wdata[0];
            default:        nxt_state.port_cfg = state_ff.port_cfg;
         endcase
      end
      // Sequencer: acquisition clocks, then the fixed conversion clocks
      case (state_ff.phase)
         PH_IDLE: begin
            if (start) begin
               nxt_state.phase   = PH_ACQ; // see (R19)
               nxt_state.div_cnt = 5'h00;
               nxt_state.step    = 7'h00;
            end
         end
         PH_ACQ, PH_CONV: begin
            nxt_state.div_cnt = tick ? 5'h00 : state_ff.div_cnt + 5'h01;
            if (tick) begin
               nxt_state.step = state_ff.step + 7'h01;
               if (state_ff.phase == PH_ACQ && state_ff.step == acq_last) begin
                  nxt_state.phase = PH_CONV; // see (R19)
                  nxt_state.step  = 7'h00;
               end
            end
            if (done) begin
               nxt_state.phase   = PH_IDLE;
               nxt_state.result  = analog_result; // see (R06)
               nxt_state.res_sgn = state_ff.control[`CTL_MODE_HI:`CTL_MODE_LO] == `MODE_DIFF;
               nxt_state.ready   = 1'b1; // see (R02)
               nxt_state.irq     = 1'b1; // see (R02)
               // A control write in this very cycle keeps the code that software chose
               if (trig == `TRIG_SW_SINGLE && !(wr_en && addr == `ADDR_CONTROL)) begin
                  nxt_state.control[`CTL_TRIG_HI:`CTL_TRIG_LO] = `TRIG_PIN; // see (R18)
               end
            end
         end
         default: nxt_state.phase = PH_IDLE;
      endcase
      // Soft reset aborts any conversion and restores defaults other than port configuration
      if (soft_rst) begin
         nxt_state.phase   = PH_IDLE; // see (R07)
         nxt_state.control = `CTL_RESET;
         nxt_state.pos_sel = 5'h00;
         nxt_state.neg_sel = 5'h00;
         nxt_state.ready   = 1'b0;
         nxt_state.result  = 12'h000;
         nxt_state.res_sgn = 1'b0;
         nxt_state.pwr_cnt = 7'h00;
         nxt_state.irq     = 1'b0;
      end
      nxt_state.busy    = nxt_state.phase != PH_IDLE; // see (R04)
      nxt_state.pin_two = nxt_state.busy && nxt_state.port_cfg; // see (R05)
      // Registered here so the pin leaves a flip-flop rather than a phase decode
      nxt_state.hold    = nxt_state.phase == PH_ACQ; // see (R19)
   end

   // ==========================================================
   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_ff <= '{phase: PH_IDLE, control: `CTL_RESET, default: '0}; // see (R08)
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================================
   // Outputs, all straight from the state register
   assign rdata                  = state_ff.rdata;
   assign positive_buffer_bypass = state_ff.control[`CTL_POS_BYP]; // see (R10)
   assign negative_buffer_bypass = state_ff.control[`CTL_NEG_BYP]; // see (R11)
   assign converter_power_up     = state_ff.control[`CTL_POWER]; // see (R16)
   assign input_mode             = state_ff.control[`CTL_MODE_HI:`CTL_MODE_LO]; // see (R17)
   assign positive_input_select  = state_ff.pos_sel;
   assign negative_input_select  = state_ff.neg_sel;
   assign sample_hold            = state_ff.hold;
   assign converter_clk_tick     = state_ff.tick;
   assign conversion_busy_output = state_ff.busy;
   assign port_zero_pin_two      = state_ff.pin_two;
   assign conversion_irq         = state_ff.irq;

   // ==========================================================
   // Checks: helper counters of core and converter clocks per conversion
   int core_cnt;  // Core clocks since start
   int tick_cnt;  // Converter clocks since start
   int div_at;    // Divider at start
   int acq_at;    // Acquisition length at start

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         core_cnt <= 0;
         tick_cnt <= 0;
         div_at   <= 0;
         acq_at   <= 0;
      end else if (start) begin
         core_cnt <= 0;
         tick_cnt <= 0;
         div_at   <= int'(div_last) + 1;
         acq_at   <= int'(acq_last) + 1;
      end else begin
         core_cnt <= core_cnt + 1;
         tick_cnt <= tick ? tick_cnt + 1 : tick_cnt;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_status_one_bit;
      rd_en && addr == `ADDR_STATUS |=> rdata[31:1] == 31'h0 && rdata[0] == $past(state_ff.ready);
   endproperty
   a_status_one_bit: assert property (p_status_one_bit) else $error("status readback wrong"); // see (R01)

   property p_done_sets;
      done && !soft_rst |=> state_ff.ready && conversion_irq ##1 !conversion_irq;
   endproperty
   a_done_sets: assert property (p_done_sets) else $error("completion did not flag"); // see (R02)

   property p_read_clears;
      rd_en && addr == `ADDR_RESULT && !done |=> !state_ff.ready;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("result read kept ready"); // see (R03)

   // Busy rises after start, stays up until the completing cycle, then drops
   property p_busy_span;
      (start |=> conversion_busy_output)
      and (conversion_busy_output && !done && !soft_rst |=> conversion_busy_output)
      and (done |=> !conversion_busy_output);
   endproperty
   a_busy_span: assert property (p_busy_span) else $error("busy not held over conversion"); // see (R04)

   property p_pin_two;
      port_zero_pin_two == (conversion_busy_output && state_ff.port_cfg);
   endproperty
   a_pin_two: assert property (p_pin_two) else $error("pin two mismatch"); // see (R05)

   property p_result_kept;
      done && !soft_rst |=> state_ff.result == $past(analog_result);
   endproperty
   a_result_kept: assert property (p_result_kept) else $error("result not captured"); // see (R06)

   property p_soft_reset;
      soft_rst |=> state_ff.control == `CTL_RESET && !state_ff.ready && !conversion_busy_output;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete"); // see (R07)

   property p_reserved_zero;
      state_ff.control[31:16] == 16'h0000 && !state_ff.control[6];
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // see (R09)

   property p_div_rate;
      done |-> core_cnt + 1 == (acq_at + `CONV_EXTRA) * div_at;
   endproperty
   a_div_rate: assert property (p_div_rate) else $error("conversion core clock count wrong"); // see (R12)

   property p_conv_len;
      done |-> tick_cnt + 1 == acq_at + `CONV_EXTRA;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("converter clock count wrong"); // see (R13)

   property p_start_gated;
      start |-> state_ff.control[`CTL_ENABLE] && state_ff.control[`CTL_POWER] && settled;
   endproperty
   a_start_gated: assert property (p_start_gated) else $error("start while disabled"); // see (R15)

   property p_single_reverts;
      done && trig == `TRIG_SW_SINGLE && !wr_en |=> trig == `TRIG_PIN;
   endproperty
   a_single_reverts: assert property (p_single_reverts) else $error("single mode kept"); // see (R18)

   // Ready survives everything but a result read or a soft reset
   property p_ready_holds;
      state_ff.ready && !(rd_en && addr == `ADDR_RESULT) && !soft_rst |=> state_ff.ready;
   endproperty
   a_ready_holds: assert property (p_ready_holds) else $error("ready flag lost"); // see (R03)

   // Acquisition ends after the number of converter clocks its code names
   property p_acq_len;
      tick && state_ff.phase == PH_ACQ && state_ff.step == acq_last && acq_code <= 3'h5
         |-> (tick_cnt + 1) == (2 << acq_code);
   endproperty
   a_acq_len: assert property (p_acq_len) else $error("acquisition length wrong"); // see (R14)

   // The core samples only inside a busy span
   property p_hold_in_busy;
      sample_hold |-> conversion_busy_output;
   endproperty
   a_hold_in_busy: assert property (p_hold_in_busy) else $error("sample hold outside busy"); // see (R19)

   c_single: cover property (done && trig == `TRIG_SW_SINGLE);
   c_cont_back: cover property (done && trig == `TRIG_SW_CONT ##1 start);
   c_read_clear: cover property (state_ff.ready ##1 rd_en && addr == `ADDR_RESULT);
   c_soft_abort: cover property (conversion_busy_output && soft_rst);
   c_pin_busy: cover property (port_zero_pin_two);

endmodule

// ---- test/analog_core_model.sv ----
// Behavioural model of the analog converter core facing the control block
module analog_core_model (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        sample_hold,
   input  wire logic        conversion_busy_output,
   input  wire logic [11:0] sample_value,
   output logic [11:0]      analog_result
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Output stage
   logic        active;   // Core is sampling or converting
   logic [11:0] last_ff;  // Last value put on the result lines

   assign active = sample_hold | conversion_busy_output;

   // Outside a conversion the lines wander every cycle, so a capture
   // taken two cycles late cannot match, though one taken one cycle late still does
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         last_ff <= 12'hA5A;
      end else if (active) begin
         last_ff <= sample_value;
      end else begin
         last_ff <= ~last_ff;
      end
   end

   // Result follows the sample value while the core samples or is busy, and for one cycle after
   assign analog_result = active ? sample_value : last_ff;
endmodule

// ---- test/testbench.sv ----
// Self-checking testbench of the converter control block
`include "adc_ctl_map.svh"
`define CHECK(nm, exp, got) begin \
   n_checks++; \
   if ((got) !== (exp)) begin \
      $display("mismatch %s expected %0h seen %0h", nm, exp, got); \
      n_errors++; \
   end \
end

module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Bench signals, all inputs valued at time zero
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [31:0] addr = 32'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic [31:0] rdata;
   logic [11:0] analog_result;
   logic [11:0] sample_value = 12'h000;
   logic        external_convert_pin = 1'b0;
   logic        timer0_trigger = 1'b0;
   logic        timer1_trigger = 1'b0;
   logic        programmable_logic_source = 1'b0;
   logic        positive_buffer_bypass;
   logic        negative_buffer_bypass;
   logic        converter_power_up;
   logic [1:0]  input_mode;
   logic [4:0]  positive_input_select;
   logic [4:0]  negative_input_select;
   logic        sample_hold;
   logic        converter_clk_tick;
   logic        conversion_busy_output;
   logic        port_zero_pin_two;
   logic        conversion_irq;
   int          n_errors = 0;
   int          n_checks = 0;

   // 20 MHz core clock
   always #25 ref_clk = ~ref_clk;

   adc_control_status_logic dut (.ref_clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .analog_result,
      .external_convert_pin, .timer0_trigger, .timer1_trigger, .programmable_logic_source,
      .positive_buffer_bypass, .negative_buffer_bypass, .converter_power_up, .input_mode,
      .positive_input_select, .negative_input_select, .sample_hold, .converter_clk_tick,
      .conversion_busy_output, .port_zero_pin_two, .conversion_irq);

   analog_core_model core (.ref_clk, .rst, .sample_hold, .conversion_busy_output, .sample_value,
      .analog_result);

   // ==========================================================
   // Register bus tasks: one-cycle strobes, read data in the next cycle
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      // Let the write settle so callers may look at outputs at once
      #1;
   endtask

   task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
      `CHECK(nm, exp, rdata)
   endtask

   // One conversion: program, fire the trigger, time busy, read back
   task automatic run_conv(input logic [2:0] trig, input logic [2:0] dv, input logic [2:0] aq,
                           input logic [1:0] md, input logic cfg, input logic [11:0] val);
      int         i;
      int         n;
      int         want;
      int         ticks;
      logic [3:0] sel;
      want = ((2 << aq) + `CONV_EXTRA) * (1 << dv);
      n = 0;
      ticks = 0;
      case (trig)
         3'h0: sel = 4'h8;
         3'h1: sel = 4'h4;
         3'h2: sel = 4'h2;
         3'h5: sel = 4'h1;
         default: sel = 4'h0;
      endcase
      sample_value <= val;
      wr(`ADDR_PORT_CFG, {31'h0, cfg});
      wr(`ADDR_CONTROL, {18'h0, dv, aq, 3'h5, md, trig});
      for (i = 0; i < 3000; i++) begin
         @(posedge ref_clk);
         // Trigger lines high for one cycle only
         {external_convert_pin, timer1_trigger, timer0_trigger, programmable_logic_source} <= (i == 0) ? sel : 4'h0;
         #1;
         ticks += int'(converter_clk_tick);
         if (conversion_busy_output) begin
            n++;
            if (n == 1) `CHECK("sample_hold", 1'b1, sample_hold)
            if (n == 3) `CHECK("pin_two", cfg, port_zero_pin_two)
         end
         if (n > 0 && !conversion_busy_output) break;
      end
      `CHECK("conv_cycles", want, n)
      `CHECK("tick_count", (2 << aq) + `CONV_EXTRA, ticks)
      `CHECK("irq", 1'b1, conversion_irq)
      @(posedge ref_clk);
      #1;
      `CHECK("restart", trig == 3'h4, conversion_busy_output)
      `CHECK("irq_end", 1'b0, conversion_irq)
      rd("status_set", `ADDR_STATUS, 32'h1);
      rd("result", `ADDR_RESULT, {{4{md == 2'h1 ? val[11] : 1'b0}}, val, 16'h0});
      rd("status_clr", `ADDR_STATUS, 32'h0);
      rd("trig_code", `ADDR_CONTROL, {18'h0, dv, aq, 3'h5, md, (trig == 3'h3) ? 3'h0 : trig});
      // Park idle and let a continuous run finish
      wr(`ADDR_CONTROL, 32'h000000A0);
      for (i = 0; i < 3000 && conversion_busy_output; i++) begin
         @(posedge ref_clk);
         #1;
      end
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset_values();
      rd("ctl_reset", `ADDR_CONTROL, `CTL_RESET);
      rd("sta_reset", `ADDR_STATUS, 32'h0);
      rd("res_reset", `ADDR_RESULT, 32'h0);
      rd("unmapped", 32'hFFFF0518, 32'h0);
      `CHECK("busy_reset", 1'b0, conversion_busy_output)
   endtask

   task automatic t_reserved_bits();
      wr(`ADDR_CONTROL, 32'hFFFFFFFF);
      rd("ctl_mask", `ADDR_CONTROL, `CTL_WR_MASK);
      `CHECK("mode", 2'h3, input_mode)
      wr(`ADDR_CONTROL, 32'hFFFF4008);
      rd("ctl_upper", `ADDR_CONTROL, 32'h00004008);
      `CHECK("pos_byp", 1'b0, positive_buffer_bypass)
      `CHECK("neg_byp", 1'b1, negative_buffer_bypass)
      `CHECK("mode_diff", `MODE_DIFF, input_mode)
      wr(`ADDR_CONTROL, 32'h00008000);
      `CHECK("pos_byp1", 1'b1, positive_buffer_bypass)
      `CHECK("neg_byp0", 1'b0, negative_buffer_bypass)
      wr(`ADDR_POS_SEL, 32'hFFFFFFFF);
      wr(`ADDR_NEG_SEL, 32'h00000015);
      `CHECK("pos_sel", 5'h1F, positive_input_select)
      `CHECK("neg_sel", 5'h15, negative_input_select)
      wr(`ADDR_CONTROL, `CTL_RESET);
   endtask

   // Power up once; the settle count then stays satisfied
   task automatic t_power_up();
      wr(`ADDR_CONTROL, 32'h000000A0);
      repeat (`PWR_CYC + 10) @(posedge ref_clk);
      #1;
      `CHECK("power", 1'b1, converter_power_up)
   endtask

   task automatic t_dividers();
      for (int d = 0; d < 6; d++) run_conv(`TRIG_SW_SINGLE, d[2:0], 3'h0, 2'h0, d[0], 12'h8C5 ^ 12'(d));
   endtask

   task automatic t_acquisition();
      for (int a = 0; a < 4; a++) run_conv(`TRIG_SW_SINGLE, 3'h1, a[2:0], 2'h2, 1'b1, 12'h3A0 + 12'(a));
   endtask

   task automatic t_triggers();
      logic [2:0] codes [5] = '{`TRIG_PIN, `TRIG_TIMER1, `TRIG_TIMER0, `TRIG_SW_CONT, `TRIG_PLA};
      foreach (codes[k]) run_conv(codes[k], 3'h0, 3'h0, 2'h0, 1'b0, 12'h5E1 + 12'(k));
   endtask

   task automatic t_differential();
      run_conv(`TRIG_SW_SINGLE, 3'h0, 3'h0, `MODE_DIFF, 1'b1, 12'h9AB);
   endtask

   // Conversions disabled: a software trigger must not start anything
   task automatic t_gate();
      logic seen;
      seen = 1'b0;
      wr(`ADDR_CONTROL, 32'h00000023);
      repeat (60) begin
         @(posedge ref_clk);
         #1;
         seen = seen | conversion_busy_output;
      end
      `CHECK("gated", 1'b0, seen)
      rd("gate_ctl", `ADDR_CONTROL, 32'h00000023);
   endtask

   // Soft reset in mid-conversion aborts it and restores defaults
   task automatic t_soft_reset();
      wr(`ADDR_CONTROL, 32'h00002BA3);
      repeat (20) @(posedge ref_clk);
      #1;
      `CHECK("busy_mid", 1'b1, conversion_busy_output)
      wr(`ADDR_SOFT_RST, 32'h1);
      #1;
      `CHECK("busy_abort", 1'b0, conversion_busy_output)
      rd("ctl_soft", `ADDR_CONTROL, `CTL_RESET);
      rd("res_soft", `ADDR_RESULT, 32'h0);
      rd("sel_soft", `ADDR_POS_SEL, 32'h0);
      `CHECK("power_soft", 1'b0, converter_power_up)
   endtask

   // ==========================================================
   // Verdict and run control
   task automatic finish_test();
      if (n_errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset_values();
      t_reserved_bits();
      t_power_up();
      t_dividers();
      t_acquisition();
      t_triggers();
      t_differential();
      t_gate();
      t_soft_reset();
      finish_test();
   end

   // Whole run needs well under 10000 cycles; this cuts a hang short
   initial begin
      repeat (60000) @(posedge ref_clk);
      n_errors++;
      finish_test();
   end
endmodule
